// ===== hdl/analog_die_defines.svh
// register offsets, windows and fixed values of the analog die register bank
`ifndef ANALOG_DIE_DEFINES_SVH
`define ANALOG_DIE_DEFINES_SVH

`define BLOCKING_BASE 16'h0200
`define NONBLOCKING_BASE 16'h0300
`define WINDOW_MASK 16'hff00

`define WAKE_LEVELS_OFS 8'h08
`define WAKE_CTRL_IN_OFS 8'h09
`define WAKE_CONTROL_OFS 8'h12
`define WAKE_SOURCE_OFS 8'h14
`define CURRENT_SENSE_OFS 8'h3c
`define ADC_SEL_HIGH_OFS 8'h82
`define ADC_SEL_LOW_OFS 8'h83
`define ADC_DONE_HIGH_OFS 8'h84
`define ADC_DONE_LOW_OFS 8'h85
`define ADC_RESULT_FIRST 8'h8c
`define ADC_CH7_RESULT_HIGH 8'h94
`define ADC_RESULT_LAST 8'h99
`define SILICON_REV_OFS 8'hf4

`define RESET_VALUE 8'h00
`define CURRENT_SENSE_VALID 8'h8f
`define ADC_HIGH_VALID 8'hdf
`define SIX_INPUT_BITS 8'h3f
`define SIX_INPUT_RESET 6'h00
`define WAKE_PRESENT_FULL 6'h3f
`define WAKE_PRESENT_REDUCED 6'h0f
`define ABSENT_WAKE_BITS 8'h30
`define ABSENT_CH9_HIGH 8'h02
`define ABSENT_CH8_HIGH 8'h01
`define ABSENT_CH7_LOW 8'h80
`define ALL_BITS 8'hff
`define NO_BITS 8'h00

`define FULL_MASK_REV 2'h0
`define METAL_MASK_REV 2'h0
`define REV_UPPER_ZERO 4'h0
`define FORCED_WAKE_BIT 7
`define BUS_WAKE_BIT 6
`define RESULT_LOW_PAD 6'h00

`endif

// ===== hdl/analog_die_pkg.sv
// types and option masking shared by both ends of the analog die register bus
`include "analog_die_defines.svh"

package analog_die_pkg;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] prev;
    logic [5:0] input_ctl;
    logic [7:0] wake_ctl;
    logic [7:0] wake_src;
    logic [7:0] cs_ctl;
    logic [15:0] adc_sel;
    logic [7:0] rdata;
    logic ack;
    logic err;
  } dev_state_s;

  typedef enum logic [1:0] {
    host_idle = 2'b01,
    host_wait = 2'b10
  } host_state_e;

  typedef struct packed {
    host_state_e state;
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] ofs;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_err;
  } host_state_s;

  // bits that belong to absent features in the reduced option
  function automatic logic [7:0] absent_mask(input logic [7:0] ofs, input logic full);
    logic [7:0] m;
    m = `NO_BITS;
    if (!full) begin
      unique case (ofs)
        `WAKE_LEVELS_OFS, `WAKE_CTRL_IN_OFS, `WAKE_CONTROL_OFS, `WAKE_SOURCE_OFS: m = `ABSENT_WAKE_BITS;
        `CURRENT_SENSE_OFS: m = `ALL_BITS;
        `ADC_SEL_HIGH_OFS, `ADC_DONE_HIGH_OFS: m = `ABSENT_CH9_HIGH | `ABSENT_CH8_HIGH;
        `ADC_SEL_LOW_OFS, `ADC_DONE_LOW_OFS: m = `ABSENT_CH7_LOW;
        default: begin
          if (ofs >= `ADC_CH7_RESULT_HIGH && ofs <= `ADC_RESULT_LAST) begin
            m = `ALL_BITS;
          end
        end
      endcase
    end
    return m;
  endfunction

endpackage

// ===== hdl/d2d_reg_if.sv
// die-to-die register bus between controller and analog die
`timescale 1ns/10ps
interface d2d_reg_if;
  logic req;
  logic we;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic err;

  modport device (input req, input we, input addr, input wdata, output rdata, output ack, output err);
  modport host (output req, output we, output addr, output wdata, input rdata, input ack, input err);
endinterface

// ===== hdl/analog_die_regs.sv
// analog die register bank with option-dependent features
//
// Behaviour
// - revision register at 0xf4, upper nibble zero
// - revision hardwired constant, writes ignored
// - decode offsets under 0x0200 and 0x300
// - reduced option: no current sense, channel 9
// - wake inputs L0-L5 full, L0-L3 reduced
// - host keeps current sense control at zero
// - host writes zero to channel 9 select
// - host ignores channel 9 completion and result
// - host ignores absent bits of input levels
// - host writes zero to absent input controls
// - absent inputs never wake; enables kept zero
// - host ignores absent wake source flags
// - wake source: forced, bus, six inputs
// - host writes zero to absent input channels
// - host ignores absent input channel results
// - absent inputs: no wake, level, conversion
`timescale 1ns/10ps
module analog_die_regs
  import analog_die_pkg::*;
#(
  parameter logic full_option = 1'b1,
  parameter logic [1:0] full_mask_revision = `FULL_MASK_REV,
  parameter logic [1:0] metal_mask_revision = `METAL_MASK_REV
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register bus
  d2d_reg_if.device bus,
  // wake pins and events
  input wire logic [5:0] wake_pins,
  input wire logic forced_wake_event,
  input wire logic bus_wake_event,
  // adc side
  input wire logic [15:0] adc_complete_in,
  input wire logic [6:0][9:0] adc_result_in,
  // control outputs
  output logic [5:0] wake_input_disable_bit,
  output logic [5:0] wake_input_enable_bit,
  output logic [1:0] cyclic_sense_select,
  output logic [7:0] current_sense_control,
  output logic [15:0] adc_channel_select,
  output logic [7:0] wake_source_flags
);

  dev_state_s r;
  dev_state_s n;
  logic [5:0] present;
  logic hit;
  logic [7:0] ofs;
  logic [7:0] amask;
  logic [7:0] rel;
  logic [2:0] ridx;
  logic [7:0] rd;
  logic [5:0] rise;

  assign present = full_option ? `WAKE_PRESENT_FULL : `WAKE_PRESENT_REDUCED;

  always_comb begin
    n = r;
    n.ack = 1'b0;
    n.err = 1'b0;
    n.rdata = `RESET_VALUE;
    rd = `RESET_VALUE;
    rel = `RESET_VALUE;
    ridx = 3'h0;
    // raw pins go straight into the first stage; absent ones are masked after it
    n.sync1 = wake_pins;
    n.sync2 = r.sync1;
    n.prev = r.sync2;
    ofs = bus.addr[7:0];
    hit = ((bus.addr & `WINDOW_MASK) == `BLOCKING_BASE) ||
          ((bus.addr & `WINDOW_MASK) == `NONBLOCKING_BASE);
    amask = absent_mask(ofs, full_option);
    rise = r.sync2 & ~r.prev & r.wake_ctl[5:0] & ~r.input_ctl & present;
    if (bus.req) begin
      n.ack = 1'b1;
      if (!hit) begin
        n.err = 1'b1;
      end else begin
        unique case (ofs)
          `WAKE_LEVELS_OFS: rd = {2'b00, r.sync2 & present};
          `WAKE_CTRL_IN_OFS: begin
            rd = {2'b00, r.input_ctl};
            if (bus.we) begin
              n.input_ctl = bus.wdata[5:0] & ~amask[5:0];
            end
          end
          `WAKE_CONTROL_OFS: begin
            rd = r.wake_ctl;
            if (bus.we) begin
              n.wake_ctl = bus.wdata & ~amask;
            end
          end
          `WAKE_SOURCE_OFS: begin
            rd = r.wake_src;
            // reading clears; events below are applied after so they win
            if (!bus.we) begin
              n.wake_src = `RESET_VALUE;
            end
          end
          `CURRENT_SENSE_OFS: begin
            rd = r.cs_ctl;
            if (bus.we) begin
              n.cs_ctl = bus.wdata & `CURRENT_SENSE_VALID & ~amask;
            end
          end
          `ADC_SEL_HIGH_OFS: begin
            rd = r.adc_sel[15:8];
            if (bus.we) begin
              n.adc_sel[15:8] = bus.wdata & `ADC_HIGH_VALID & ~amask;
            end
          end
          `ADC_SEL_LOW_OFS: begin
            rd = r.adc_sel[7:0];
            if (bus.we) begin
              n.adc_sel[7:0] = bus.wdata & ~amask;
            end
          end
          `ADC_DONE_HIGH_OFS: rd = adc_complete_in[15:8] & `ADC_HIGH_VALID;
          `ADC_DONE_LOW_OFS: rd = adc_complete_in[7:0];
          `SILICON_REV_OFS: rd = {`REV_UPPER_ZERO, full_mask_revision, metal_mask_revision};
          default: begin
            if (ofs >= `ADC_RESULT_FIRST && ofs <= `ADC_RESULT_LAST) begin
              rel = ofs - `ADC_RESULT_FIRST;
              ridx = rel[3:1];
              rd = rel[0] ? {adc_result_in[ridx][1:0], `RESULT_LOW_PAD} : adc_result_in[ridx][9:2];
            end else begin
              n.err = 1'b1;
            end
          end
        endcase
        n.rdata = rd & ~amask;
      end
    end
    // sticky wake sources, set wins over read clear
    n.wake_src[5:0] = n.wake_src[5:0] | rise;
    n.wake_src[`FORCED_WAKE_BIT] = n.wake_src[`FORCED_WAKE_BIT] | forced_wake_event;
    n.wake_src[`BUS_WAKE_BIT] = n.wake_src[`BUS_WAKE_BIT] | bus_wake_event;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bus.rdata = r.rdata;
  assign bus.ack = r.ack;
  assign bus.err = r.err;
  assign wake_input_disable_bit = r.input_ctl;
  assign wake_input_enable_bit = r.wake_ctl[5:0];
  assign cyclic_sense_select = r.wake_ctl[7:6];
  assign current_sense_control = r.cs_ctl;
  assign adc_channel_select = r.adc_sel;
  assign wake_source_flags = r.wake_src;

endmodule

// ===== hdl/analog_die_host.sv
// controller end: issues register accesses and hides absent features
`timescale 1ns/10ps
module analog_die_host
  import analog_die_pkg::*;
#(
  parameter logic full_option = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // command port
  input wire logic cmd_valid,
  input wire logic cmd_we,
  input wire logic cmd_nonblocking,
  input wire logic [7:0] cmd_offset,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  // response port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_err,
  // register bus
  d2d_reg_if.host bus
);

  host_state_s r;
  host_state_s n;
  logic [7:0] amask;

  assign cmd_ready = (r.state == host_idle);

  always_comb begin
    n = r;
    n.req = 1'b0;
    n.rsp_valid = 1'b0;
    amask = absent_mask(cmd_offset, full_option);
    unique case (r.state)
      host_idle: begin
        if (cmd_valid) begin
          n.req = 1'b1;
          n.we = cmd_we;
          n.ofs = cmd_offset;
          n.addr = (cmd_nonblocking ? `NONBLOCKING_BASE : `BLOCKING_BASE) | {8'h00, cmd_offset};
          // absent control bits always written as zero
          n.wdata = cmd_wdata & ~amask;
          n.state = host_wait;
        end
      end
      host_wait: begin
        amask = absent_mask(r.ofs, full_option);
        if (bus.ack) begin
          n.rsp_valid = 1'b1;
          n.rsp_err = bus.err;
          n.rsp_data = bus.rdata & ~amask;
          n.state = host_idle;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= '{state: host_idle, default: '0};
    end else begin
      r <= n;
    end
  end

  assign bus.req = r.req;
  assign bus.we = r.we;
  assign bus.addr = r.addr;
  assign bus.wdata = r.wdata;
  assign rsp_valid = r.rsp_valid;
  assign rsp_data = r.rsp_data;
  assign rsp_err = r.rsp_err;

endmodule

// ===== sim/analog_die_checker.sv
// assertions on the register bus between host and device ends
`timescale 1ns/10ps
`include "analog_die_defines.svh"
module analog_die_checker #(
  parameter logic full_option = 1'b1
) (
  // clock and reset
  input logic ref_clk,
  input logic reset,
  // bus signals
  input logic req,
  input logic we,
  input logic [15:0] addr,
  input logic [7:0] wdata,
  input logic [7:0] rdata,
  input logic ack,
  input logic err
);
  logic rd;
  logic wr;
  logic [7:0] ofs;
  assign rd = req && !we;
  assign wr = req && we && !full_option;
  assign ofs = addr[7:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  ack_next_a: assert property (req |=> ack) else $error("no answer");
  ack_cause_a: assert property (ack |-> $past(req)) else $error("stray answer");
  one_req_a: assert property (req |=> !req) else $error("request too long");
  win_addr_a: assert property (req |-> addr[15:9] == 7'h01) else $error("bad window");
  err_ack_a: assert property (err |-> ack) else $error("error without answer");
  rev_read_a: assert property (rd && ofs == `SILICON_REV_OFS |=> !err &&
    rdata == {`REV_UPPER_ZERO, `FULL_MASK_REV, `METAL_MASK_REV}) else $error("bad revision");
  cs_write_a: assert property (wr && ofs == `CURRENT_SENSE_OFS |-> wdata == `NO_BITS)
    else $error("sense control written");
  ch9_sel_a: assert property (wr && ofs == `ADC_SEL_HIGH_OFS |-> wdata[1:0] == 2'h0)
    else $error("absent channel selected");
  lx_write_a: assert property (wr && ofs inside {8'h09, 8'h12} |-> wdata[5:4] == 2'h0)
    else $error("absent input written");
  ch9_read_a: assert property (rd && !full_option && ofs[7:1] == 7'h4c |=> rdata == `NO_BITS)
    else $error("channel 9 result seen");
  lvl_read_a: assert property (rd && ofs == 8'h08 |=> rdata[7:6] == 2'h0 &&
    (full_option || rdata[5:4] == 2'h0)) else $error("bad input levels");
  wake_read_a: assert property (rd && !full_option && ofs == 8'h14 |=> rdata[5:4] == 2'h0)
    else $error("absent wake flag");
  cover property (rd ##1 err);
  cover property (rd && ofs == 8'h14 ##1 rdata[7:6] == 2'h3);
  cover property (wr);
endmodule

// ===== sim/tb_top.sv
// bench for the host and device pair in the reduced option
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_fail++; \
  $display("[ERR] %s expected %h seen %h", n, e, s); end end
module tb_top;
  import analog_die_pkg::*;
  typedef struct packed {logic we; logic nb; logic [7:0] o; logic [7:0] d; logic e;} row_s;
  logic ref_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, cmd_we = 1'b0, cmd_nonblocking = 1'b0;
  logic [7:0] cmd_offset = 8'h00, cmd_wdata = 8'h00;
  logic cmd_ready, rsp_valid, rsp_err;
  logic [7:0] rsp_data, current_sense_control, wake_source_flags;
  logic [15:0] adc_channel_select;
  logic [5:0] wake_input_disable_bit, wake_input_enable_bit;
  logic [1:0] cyclic_sense_select;
  logic [5:0] wake_pins = 6'h3f;
  logic forced_wake_event = 1'b0, bus_wake_event = 1'b0;
  logic [15:0] adc_complete_in = 16'hffff;
  logic [6:0][9:0] adc_result_in = {7{10'h2c5}};
  int checks = 0, n_fail = 0;
  // reads carry the expected data in d
  row_s rows [19] = '{
    '{1'b1, 1'b0, 8'h3c, 8'hff, 1'b0},
    '{1'b0, 1'b0, 8'h3c, 8'h00, 1'b0},
    '{1'b1, 1'b0, 8'h82, 8'hff, 1'b0},
    '{1'b0, 1'b1, 8'h82, 8'hdc, 1'b0},
    '{1'b1, 1'b1, 8'h83, 8'hff, 1'b0},
    '{1'b0, 1'b0, 8'h83, 8'h7f, 1'b0},
    '{1'b1, 1'b0, 8'h09, 8'hff, 1'b0},
    '{1'b0, 1'b0, 8'h09, 8'h0f, 1'b0},
    '{1'b1, 1'b1, 8'h12, 8'hff, 1'b0},
    '{1'b0, 1'b0, 8'h12, 8'hcf, 1'b0},
    '{1'b1, 1'b0, 8'hf4, 8'hff, 1'b0},
    '{1'b0, 1'b0, 8'hf4, 8'h00, 1'b0},
    '{1'b0, 1'b0, 8'h40, 8'h00, 1'b1},
    '{1'b0, 1'b0, 8'h98, 8'h00, 1'b0},
    '{1'b0, 1'b1, 8'h8c, 8'hb1, 1'b0},
    '{1'b0, 1'b0, 8'h8d, 8'h40, 1'b0},
    '{1'b0, 1'b0, 8'h94, 8'h00, 1'b0},
    '{1'b0, 1'b0, 8'h85, 8'h7f, 1'b0},
    '{1'b0, 1'b0, 8'h08, 8'h0f, 1'b0}};
  d2d_reg_if link ();
  analog_die_host #(.full_option(1'b0)) i_analog_die_host (.ref_clk, .reset, .cmd_valid, .cmd_we,
    .cmd_nonblocking, .cmd_offset, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_data, .rsp_err, .bus(link));
  analog_die_regs #(.full_option(1'b0)) i_analog_die_regs (.ref_clk, .reset, .bus(link), .wake_pins,
    .forced_wake_event, .bus_wake_event, .adc_complete_in, .adc_result_in, .wake_input_disable_bit,
    .wake_input_enable_bit, .cyclic_sense_select, .current_sense_control, .adc_channel_select,
    .wake_source_flags);
  analog_die_checker #(.full_option(1'b0)) i_chk (.ref_clk, .reset, .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .err(link.err));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // response lands two rising edges after the taking edge
  task automatic cmd(input row_s r);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    {cmd_we, cmd_nonblocking, cmd_offset, cmd_wdata} = {r.we, r.nb, r.o, r.d};
    @(posedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("rsp_valid", 1'b1, rsp_valid)
    `CHK("rsp_err", r.e, rsp_err)
    if (!r.we)
      `CHK("rsp_data", r.d, rsp_data)
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    foreach (rows[i]) cmd(rows[i]);
    $display("table test done");
    `CHK("current_sense_control", 8'h00, current_sense_control)
    `CHK("adc_channel_select", 16'h0000, adc_channel_select & 16'h0380)
    `CHK("wake_input_disable_bit", 6'h0f, wake_input_disable_bit)
    `CHK("wake_input_enable_bit", 6'h0f, wake_input_enable_bit)
    `CHK("cyclic_sense_select", 2'h3, cyclic_sense_select)
    $display("output test done");
    wake_pins = 6'h00;
    cmd('{1'b1, 1'b0, 8'h09, 8'h00, 1'b0});
    cmd('{1'b1, 1'b0, 8'h12, 8'h3f, 1'b0});
    cmd('{1'b0, 1'b0, 8'h14, 8'h00, 1'b0});
    @(negedge ref_clk);
    wake_pins = 6'h3f;
    forced_wake_event = 1'b1;
    @(negedge ref_clk);
    forced_wake_event = 1'b0;
    bus_wake_event = 1'b1;
    @(negedge ref_clk);
    bus_wake_event = 1'b0;
    repeat (4) @(negedge ref_clk);
    `CHK("wake_source_flags", 8'hcf, wake_source_flags)
    cmd('{1'b0, 1'b0, 8'h14, 8'hcf, 1'b0});
    cmd('{1'b0, 1'b1, 8'h14, 8'h00, 1'b0});
    $display("wake test done");
    @(negedge ref_clk);
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    `CHK("cmd_ready", 1'b1, cmd_ready)
    cmd('{1'b0, 1'b0, 8'h12, 8'h00, 1'b0});
    $display("reset test done");
    wrap_up();
  end
  // about thirty times the expected run
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_fail++;
    wrap_up();
  end
endmodule
